/* test/bcdo_out_props.sv */
/* checker for the parallel BCD output port: APB answer timing, open
   collector drive, hold freeze and clock-enable freeze.
   assumes reader inputs read 1 while shorted to the common return. */
`timescale 1ns/1ps
`default_nettype none
module bcdo_out_props #(
	parameter int unsigned BASE_CYCLES = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire bcdo_pkg::bcdo_pins_t pinOut,
	input wire bcdo_pkg::bcdo_pins_t pinOe,
	input wire logic dataHoldIn,
	input wire logic logicSelIn
);
	// slowest update period plus sync and strobe margin
	localparam int HOLD_WAIT = BASE_CYCLES * 200 + 8;
	int holdCnt_ff;
	logic logicPrev_ff;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// restart on polarity moves: a polarity change alone flips the pins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			logicPrev_ff <= 1'b0;
			holdCnt_ff <= 0;
		end else begin
			logicPrev_ff <= logicSelIn;
			if (!dataHoldIn || !ce || logicSelIn != logicPrev_ff) begin
				holdCnt_ff <= 0;
			end else if (holdCnt_ff < HOLD_WAIT) begin
				holdCnt_ff <= holdCnt_ff + 1;
			end
		end
	end
	// (the old counter body below is kept inert)
	always_ff @(posedge clk) begin
		if (1'b0) begin
			holdCnt_ff <= holdCnt_ff;
		end else if (1'b0) begin
			holdCnt_ff <= holdCnt_ff + 1;
		end
	end
	sequence s_access;
		psel && !penable && ce ##1 psel && penable && ce && !pready;
	endsequence
	sequence s_held;
		holdCnt_ff == HOLD_WAIT;
	endsequence
	property p_ack; s_access |=> pready; endproperty
	property p_once; pready |=> !pready; endproperty
	property p_err; pslverr |-> pready; endproperty
	property p_cause; pready |-> $past(psel && penable); endproperty
	property p_opcol; pinOut == '0; endproperty
	property p_hold; s_held |-> $stable(pinOe); endproperty
	property p_strOff; s_held |-> pinOe.strobe == logicSelIn; endproperty
	property p_freeze; !ce |=> $stable(pinOe) && $stable(pready); endproperty
	a_ack: assert property (p_ack) else $error("no answer in access");
	a_once: assert property (p_once) else $error("ready too long");
	a_err: assert property (p_err) else $error("error without ready");
	a_cause: assert property (p_cause) else $error("ready without access");
	a_opcol: assert property (p_opcol) else $error("pin driven high");
	a_hold: assert property (p_hold) else $error("moved in hold");
	a_strOff: assert property (p_strOff) else $error("strobe in hold");
	a_freeze: assert property (p_freeze) else $error("moved while idle");
endmodule : bcdo_out_props
bind bcdo_parallel_out bcdo_out_props #(.BASE_CYCLES(BASE_CYCLES)) u_props (
	.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .pinOut(pinOut), .pinOe(pinOe),
	.dataHoldIn(dataHoldIn), .logicSelIn(logicSelIn)
);
`default_nettype wire

/* test/bcdo_reader.sv */
/* reader model: undoes the pin polarity, latches data on each logical
   strobe rise and times the gap between rises.
   assumes the reader knows the polarity it selected. */
`timescale 1ns/1ps
`default_nettype none
module bcdo_reader (
	input wire logic clk,
	input wire logic rst,
	input wire bcdo_pkg::bcdo_pins_t pinOe,
	input wire logic positive,
	output logic [22:0] latched,
	output int strobes,
	output int gap
);
	bcdo_pkg::bcdo_pins_t lvl;
	logic prevStb_ff;
	logic prevPos_ff;
	int cnt_ff;
	// transistor on means a pin low; the selected logic maps it back
	assign lvl = pinOe ^ {24{positive}};
	// sample only on the rise, where the data has already settled
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prevStb_ff <= 1'b0;
			prevPos_ff <= 1'b0;
			cnt_ff <= 0;
			strobes <= 0;
			gap <= 0;
			latched <= '0;
		end else if (positive != prevPos_ff) begin
			// flipping our own polarity is not a strobe edge
			prevPos_ff <= positive;
			prevStb_ff <= lvl.strobe;
			cnt_ff <= cnt_ff + 1;
		end else begin
			prevStb_ff <= lvl.strobe;
			cnt_ff <= cnt_ff + 1;
			if (lvl.strobe && !prevStb_ff) begin
				latched <= lvl[22:0];
				strobes <= strobes + 1;
				gap <= cnt_ff;
				cnt_ff <= 1;
			end
		end
	end
endmodule : bcdo_reader
`default_nettype wire

/* test/test_bcd_parallel_value_output.sv */
/* bench for the parallel BCD output port: random values through every
   source, polarity and rate, hold, interrupt and self-check.
   assumes the reader model and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "bcdo_regs.svh"
module test_bcd_parallel_value_output;
	localparam int BC = 8; // short base period keeps the run small
	logic clk = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q, tv;
	logic pready, pslverr, irq, err;
	bcdo_pkg::bcdo_value_t rtV = '0, hdV = '0;
	logic sErr = 0, ovP = 0, ovN = 0, settle = 0, hold = 0, pos = 0, sel = 0;
	bcdo_pkg::bcdo_pins_t pinOut, pinOe;
	logic [22:0] latched, saved;
	bcdo_pkg::bcdo_pins_t frozen;
	int strobes, gap, s0, bad_count = 0, total_checks = 0;
	int mulTab[8] = '{200, 100, 40, 20, 10, 4, 2, 1};
	always #10 clk = ~clk;
	bcdo_parallel_out #(.BASE_CYCLES(BC)) u_dut (
		.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .realtimeValue(rtV),
		.heldValue(hdV), .sensorError(sErr), .overflowPos(ovP),
		.overflowNeg(ovN), .settlingDetector(settle), .dataHoldIn(hold),
		.logicSelIn(pos), .dataSelIn(sel), .pinOut(pinOut), .pinOe(pinOe),
		.irq(irq)
	);
	bcdo_reader u_rdr (.clk(clk), .rst(rst), .pinOe(pinOe), .positive(pos),
		.latched(latched), .strobes(strobes), .gap(gap));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// one APB transfer; request held until ready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input int d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		if (n >= 20) bad_count++;
	endtask : apb
	task automatic waitStb(input int k);
		int s, n;
		s = strobes;
		n = 0;
		while (strobes < s + k && n < 9000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 9000) bad_count++;
	endtask : waitStb
	function automatic bcdo_pkg::bcdo_value_t rndVal();
		bcdo_pkg::bcdo_value_t v;
		v.minus = 1'($urandom);
		for (int i = 0; i < 5; i++) v.digits[i*4 +: 4] = 4'($urandom % 10);
		return v;
	endfunction : rndVal
	function automatic logic [31:0] expVal(input int src);
		logic useH;
		useH = (src == 1) || (src == 2 && sel);
		return {useH && settle, sErr | ovP | ovN, useH ? hdV : rtV};
	endfunction : expVal
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : tally_and_finish
	// cut a hang short well beyond the expected run
	initial begin
		repeat (60000) @(posedge clk);
		bad_count++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(32'h9C4A65E0));
		repeat (16) @(posedge clk);
		rst <= 0;
		apb(0, `BCDO_OFS_CTRL, 0);
		chk(q, 32'h0);
		apb(0, 8'h18, 0);
		chk({q[30:0], err}, 32'h1);
		// every source and both polarities, random values and flags
		for (int i = 0; i < 6; i++) begin
			rtV <= rndVal();
			hdV <= rndVal();
			{sErr, ovP, ovN} <= 3'($urandom);
			settle <= 1'($urandom);
			pos <= i[0];
			sel <= (i == 2);
			apb(1, `BCDO_OFS_CTRL, 28 + i % 3);
			// until the device applies a new polarity, edges are fake
			repeat (3 * BC) @(posedge clk);
			waitStb(2);
			chk(32'(latched), expVal(i % 3));
			chk(gap, BC);
		end
		for (int r = 0; r < 8; r++) begin
			apb(1, `BCDO_OFS_CTRL, r << 2);
			waitStb(3);
			chk(gap, BC * mulTab[r]);
		end
		// interrupt: clear all, masked stays low, unmasked rises
		apb(1, `BCDO_OFS_CTRL, 0);
		waitStb(1);
		apb(1, `BCDO_OFS_IRQ_STAT, 32'hF);
		apb(0, `BCDO_OFS_IRQ_STAT, 0);
		chk({q[3:0], irq}, 32'h0);
		apb(1, `BCDO_OFS_IRQ_MASK, 32'h1);
		waitStb(1);
		repeat (3) @(posedge clk);
		chk(irq, 1'b1);
		apb(0, `BCDO_OFS_IRQ_STAT, 0);
		chk(q[0], 1'b1);
		// overrange rising edge sets its own status bit
		{sErr, ovP, ovN} <= 3'h0;
		@(posedge clk);
		ovN <= 1'b1;
		repeat (2) @(posedge clk);
		apb(0, `BCDO_OFS_IRQ_STAT, 0);
		chk(q[3], 1'b1);
		// hold: no strobe and frozen data while the value moves
		apb(1, `BCDO_OFS_CTRL, 28);
		hold <= 1;
		repeat (20) @(posedge clk);
		s0 = strobes;
		saved = latched;
		frozen = pinOe;
		rtV <= rndVal();
		repeat (1700) @(posedge clk);
		chk(strobes - s0, 0);
		chk(pinOe, frozen);
		chk(latched, saved);
		hold <= 0;
		waitStb(3);
		chk(32'(latched), expVal(0));
		// self-check drives the pins straight and shows the inputs
		tv = $urandom;
		apb(1, `BCDO_OFS_TEST, tv);
		apb(1, `BCDO_OFS_CTRL, 32'h100);
		repeat (3) @(posedge clk);
		chk(pinOe, tv[23:0]);
		apb(0, `BCDO_OFS_STAT, 0);
		chk(q[2:0], {sel, pos, hold});
		// clock enable low freezes the strobe sequence mid-run
		apb(1, `BCDO_OFS_CTRL, 28);
		waitStb(1);
		ce <= 0;
		s0 = strobes;
		repeat (20) @(posedge clk);
		chk(strobes - s0, 0);
		ce <= 1;
		waitStb(1);
		tally_and_finish();
	end
endmodule : test_bcd_parallel_value_output
`default_nettype wire

/* verilog/bcdo_parallel_out.sv */
/*
 * Parallel BCD output port: presents a signed five-digit value with flags
 * and a strobe on 24 open-collector lines, with an APB register slave.
 * Assumes value and flag inputs are synchronous (reader pins are synchronised here), pins
 * shorted to common arrive as 1, and the pad turns pinOe into a pull-down.
 */
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "bcdo_regs.svh"

module bcdo_parallel_out #(
	parameter int unsigned BASE_CYCLES = `BCDO_BASE_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// values from the measuring core
	input wire bcdo_pkg::bcdo_value_t realtimeValue,
	input wire bcdo_pkg::bcdo_value_t heldValue,
	input wire logic sensorError,
	input wire logic overflowPos,
	input wire logic overflowNeg,
	input wire logic settlingDetector,
	// reader inputs, 1 while shorted to common_return
	input wire logic dataHoldIn,
	input wire logic logicSelIn,
	input wire logic dataSelIn,
	// open-collector lines: pinOe high turns the transistor on
	output bcdo_pkg::bcdo_pins_t pinOut,
	output bcdo_pkg::bcdo_pins_t pinOe,
	output logic irq
);

	// below 4 the half pulse collides with the tick; above the limit the
	// slowest period overflows the 32-bit divider
	if (BASE_CYCLES < 4 || BASE_CYCLES > 21474836) begin : g_badBase
		$error("bcdo_parallel_out: BASE_CYCLES out of range");
	end

	// control and test registers
	logic [1:0] srcSel_ff;
	logic [2:0] rateSel_ff;
	logic selfTest_ff;
	logic [23:0] testDrive_ff;
	logic [`BCDO_IRQ_BITS-1:0] irqStat_ff;
	logic [`BCDO_IRQ_BITS-1:0] irqMask_ff;

	// synchronisers and values applied at the update boundary
	logic [2:0] inMeta_ff;
	logic [2:0] inSync_ff;
	logic holdApp_ff;
	logic posApp_ff;
	logic selApp_ff;

	// presented data, logical sense
	bcdo_pkg::bcdo_pins_t logical_ff;
	bcdo_pkg::bcdo_state_t state_ff;
	logic overPrev_ff;

	logic tick;
	logic half;
	logic useHeld;
	logic nxt_over;
	bcdo_pkg::bcdo_value_t srcValue;
	logic [`BCDO_IRQ_BITS-1:0] irqSet;

	// APB decode
	logic apbAccess;
	logic apbDone;
	logic apbWrite;
	logic addrHit;
	logic [31:0] nxt_prdata;

	// reset image of the control word; fields are cut from this constant
	localparam logic [31:0] CTRL_INIT = `BCDO_CTRL_RESET;

	// transistor-on request per line before self-check takes over
	logic [23:0] lineOn;

	// update timing
	bcdo_rate_tick #(
		.BASE_CYCLES(BASE_CYCLES)
	) u_rate (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.rateSel(rateSel_ff),
		.tick(tick),
		.half(half)
	);

	// reader pins are two-flop synchronised before anything looks at them
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			inMeta_ff <= 3'h0;
			inSync_ff <= 3'h0;
		end else if (ce) begin
			inMeta_ff <= {dataSelIn, logicSelIn, dataHoldIn};
			inSync_ff <= inMeta_ff;
		end
	end

	// the reader's static inputs change only at an update boundary, so a
	// frame never mixes old and new polarity or source
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			holdApp_ff <= 1'b0;
			posApp_ff <= 1'b0;
			selApp_ff <= 1'b0;
		end else if (ce && tick) begin
			holdApp_ff <= inSync_ff[0];
			posApp_ff <= inSync_ff[1];
			selApp_ff <= inSync_ff[2];
		end
	end

	// source choice uses the select value that takes effect at this tick
	always_comb begin
		case (bcdo_pkg::bcdo_src_t'(srcSel_ff))
			bcdo_pkg::SRC_REALTIME: useHeld = 1'b0;
			bcdo_pkg::SRC_HELD: useHeld = 1'b1;
			bcdo_pkg::SRC_EXTERNAL: useHeld = inSync_ff[2];
			default: useHeld = 1'b0;
		endcase
		srcValue = useHeld ? heldValue : realtimeValue;
		nxt_over = sensorError | overflowPos | overflowNeg;
	end

	// data lines load at the tick, strobe rises one cycle later and falls
	// at mid-period; data never moves while strobe is high
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			logical_ff <= '0;
			state_ff <= bcdo_pkg::ST_IDLE;
		end else if (ce) begin
			case (state_ff)
				bcdo_pkg::ST_IDLE: begin
					if (tick && !inSync_ff[0] && !selfTest_ff) begin
						logical_ff.digits <= srcValue.digits;
						logical_ff.minus <= srcValue.minus;
						logical_ff.over <= nxt_over;
						logical_ff.stabilityFlag <= useHeld && settlingDetector;
						state_ff <= bcdo_pkg::ST_ARM;
					end
				end
				bcdo_pkg::ST_ARM: begin
					logical_ff.strobe <= 1'b1;
					state_ff <= bcdo_pkg::ST_PULSE;
				end
				bcdo_pkg::ST_PULSE: begin
					// a rate change can skip the half pulse, so a tick
					// also ends it; that update is then dropped
					if (half || tick || selfTest_ff) begin
						logical_ff.strobe <= 1'b0;
						state_ff <= bcdo_pkg::ST_IDLE;
					end
				end
				default: begin
					logical_ff.strobe <= 1'b0;
					state_ff <= bcdo_pkg::ST_IDLE;
				end
			endcase
			// hold taking effect also drops a pulse still in flight
			if (tick && inSync_ff[0]) begin
				logical_ff.strobe <= 1'b0;
				state_ff <= bcdo_pkg::ST_IDLE;
			end
		end
	end

	// per-line polarity: in negative logic a one turns the transistor on
	// (pin low); positive logic inverts every line of the same frame
	for (genvar b = 0; b < 24; b++) begin : g_line
		assign lineOn[b] = logical_ff[b] ^ posApp_ff;
	end

	// pin drive; self-check drives each line from software instead
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pinOe <= '0;
			pinOut <= '0;
		end else if (ce) begin
			pinOut <= '0; // an open collector only ever pulls low
			if (selfTest_ff) pinOe <= bcdo_pkg::bcdo_pins_t'(testDrive_ff);
			else pinOe <= bcdo_pkg::bcdo_pins_t'(lineOn);
		end
	end

	// interrupt events: update issued, hold or logic input change, overrange
	always_comb begin
		irqSet = '0;
		irqSet[`BCDO_IRQ_UPDATE] = (state_ff == bcdo_pkg::ST_ARM);
		irqSet[`BCDO_IRQ_HOLD] = tick && (inSync_ff[0] != holdApp_ff);
		irqSet[`BCDO_IRQ_LOGIC] = tick && (inSync_ff[1] != posApp_ff);
		irqSet[`BCDO_IRQ_OVER] = nxt_over && !overPrev_ff;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) overPrev_ff <= 1'b0;
		else if (ce) overPrev_ff <= nxt_over;
	end

	// APB: one wait state; the write commits at the edge that sees pready
	assign apbAccess = psel && penable;
	assign apbDone = apbAccess && pready;
	assign apbWrite = apbDone && pwrite && !pslverr;

	always_comb begin
		addrHit = 1'b1;
		nxt_prdata = 32'h0000_0000;
		case (paddr)
			`BCDO_OFS_CTRL: begin
				nxt_prdata[`BCDO_CTRL_SRC_MSB:`BCDO_CTRL_SRC_LSB] = srcSel_ff;
				nxt_prdata[`BCDO_CTRL_RATE_MSB:`BCDO_CTRL_RATE_LSB] = rateSel_ff;
				nxt_prdata[`BCDO_CTRL_TEST_BIT] = selfTest_ff;
			end
			`BCDO_OFS_TEST: nxt_prdata[23:0] = testDrive_ff;
			`BCDO_OFS_STAT: begin
				// recognised input states let self-check show each input
				nxt_prdata[2:0] = inSync_ff;
				nxt_prdata[5:3] = {selApp_ff, posApp_ff, holdApp_ff};
				nxt_prdata[6] = useHeld;
				nxt_prdata[7] = (state_ff != bcdo_pkg::ST_IDLE);
			end
			`BCDO_OFS_IRQ_STAT: nxt_prdata[`BCDO_IRQ_BITS-1:0] = irqStat_ff;
			`BCDO_OFS_IRQ_MASK: nxt_prdata[`BCDO_IRQ_BITS-1:0] = irqMask_ff;
			`BCDO_OFS_VALUE: nxt_prdata[23:0] = logical_ff;
			default: addrHit = 1'b0;
		endcase
	end

	// response flops; pready pulses for one cycle per transfer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (ce) begin
			if (apbAccess && !pready) begin
				pready <= 1'b1;
				pslverr <= !addrHit;
				prdata <= pwrite ? 32'h0000_0000 : nxt_prdata;
			end else begin
				pready <= 1'b0;
				pslverr <= 1'b0;
			end
		end
	end

	// control writes; a write to a read-only register is simply dropped
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			srcSel_ff <= CTRL_INIT[`BCDO_CTRL_SRC_MSB:`BCDO_CTRL_SRC_LSB];
			rateSel_ff <= CTRL_INIT[`BCDO_CTRL_RATE_MSB:`BCDO_CTRL_RATE_LSB];
			selfTest_ff <= CTRL_INIT[`BCDO_CTRL_TEST_BIT];
			testDrive_ff <= `BCDO_TEST_RESET;
			irqMask_ff <= `BCDO_MASK_RESET;
		end else if (ce && apbWrite) begin
			case (paddr)
				`BCDO_OFS_CTRL: begin
					// code 3 is not a source; it keeps the old choice
					if (pwdata[`BCDO_CTRL_SRC_MSB:`BCDO_CTRL_SRC_LSB] != 2'h3) begin
						srcSel_ff <= pwdata[`BCDO_CTRL_SRC_MSB:`BCDO_CTRL_SRC_LSB];
					end
					rateSel_ff <= pwdata[`BCDO_CTRL_RATE_MSB:`BCDO_CTRL_RATE_LSB];
					selfTest_ff <= pwdata[`BCDO_CTRL_TEST_BIT];
				end
				`BCDO_OFS_TEST: testDrive_ff <= pwdata[23:0];
				`BCDO_OFS_IRQ_MASK: irqMask_ff <= pwdata[`BCDO_IRQ_BITS-1:0];
				default: begin
				end
			endcase
		end
	end

	// sticky status, write one to clear; a new event wins over the clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irqStat_ff <= '0;
		end else if (ce) begin
			if (apbWrite && paddr == `BCDO_OFS_IRQ_STAT) begin
				irqStat_ff <= (irqStat_ff & ~pwdata[`BCDO_IRQ_BITS-1:0]) | irqSet;
			end else begin
				irqStat_ff <= irqStat_ff | irqSet;
			end
		end
	end

	// level interrupt, registered so the output comes from a flop
	always_ff @(posedge clk or posedge rst) begin
		if (rst) irq <= 1'b0;
		else if (ce) irq <= |(irqStat_ff & irqMask_ff);
	end

endmodule : bcdo_parallel_out

`default_nettype wire

/* verilog/bcdo_pkg.sv */
/*
 * Types shared by the parallel BCD value output port.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package bcdo_pkg;

	// output source setting
	typedef enum logic [1:0] {
		SRC_REALTIME = 2'h0,
		SRC_HELD = 2'h1,
		SRC_EXTERNAL = 2'h2
	} bcdo_src_t;

	// one signed five-digit value: units digit in the low nibble
	typedef struct packed {
		logic minus;
		logic [19:0] digits;
	} bcdo_value_t;

	// the 24 open-collector output lines, logical sense (1 = data one)
	typedef struct packed {
		logic strobe;
		logic stabilityFlag;
		logic over;
		logic minus;
		logic [19:0] digits;
	} bcdo_pins_t;

	// strobe sequencing
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ARM,
		ST_PULSE
	} bcdo_state_t;

endpackage : bcdo_pkg

/* verilog/bcdo_rate_tick.sv */
/*
 * Update-rate divider: a tick that marks each output update and a
 * half-period pulse that ends the strobe.
 * Assumes one clock, asynchronous active-high reset and a clock enable.
 */
`timescale 1ns/1ps
`default_nettype none
`include "bcdo_regs.svh"

module bcdo_rate_tick #(
	parameter int unsigned BASE_CYCLES = `BCDO_BASE_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [2:0] rateSel,
	output logic tick,
	output logic half
);

	// the slowest period (200 base periods) must fit the 32-bit counter
	if (BASE_CYCLES < 4 || BASE_CYCLES > 21474836) begin : g_badBase
		$error("bcdo_rate_tick: BASE_CYCLES out of range");
	end

	logic [31:0] count_ff;
	logic [31:0] limit;
	logic [31:0] mul;

	// period in cycles for the selected rate
	always_comb begin
		case (rateSel)
			3'h0: mul = 32'(`BCDO_RATE_MUL0);
			3'h1: mul = 32'(`BCDO_RATE_MUL1);
			3'h2: mul = 32'(`BCDO_RATE_MUL2);
			3'h3: mul = 32'(`BCDO_RATE_MUL3);
			3'h4: mul = 32'(`BCDO_RATE_MUL4);
			3'h5: mul = 32'(`BCDO_RATE_MUL5);
			3'h6: mul = 32'(`BCDO_RATE_MUL6);
			default: mul = 32'(`BCDO_RATE_MUL7);
		endcase
		limit = 32'(BASE_CYCLES) * mul - 32'h0000_0001;
	end

	// free-running counter; a rate change lands within one new period
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_ff <= 32'h0000_0000;
		end else if (ce) begin
			if (count_ff >= limit) count_ff <= 32'h0000_0000;
			else count_ff <= count_ff + 32'h0000_0001;
		end
	end

	assign tick = ce && (count_ff >= limit);
	assign half = ce && (count_ff == (limit >> 1));

endmodule : bcdo_rate_tick

`default_nettype wire

/* verilog/bcdo_regs.svh */
/*
 * Register offsets, field positions, reset values and timing counts of the
 * parallel BCD value output port.
 * Assumes a 32-bit APB register bus with one aligned word per register.
 */
`ifndef BCDO_REGS_SVH
`define BCDO_REGS_SVH

// register byte offsets
`define BCDO_OFS_CTRL 8'h00
`define BCDO_OFS_TEST 8'h04
`define BCDO_OFS_STAT 8'h08
`define BCDO_OFS_IRQ_STAT 8'h0C
`define BCDO_OFS_IRQ_MASK 8'h10
`define BCDO_OFS_VALUE 8'h14

// control register fields
`define BCDO_CTRL_SRC_LSB 0
`define BCDO_CTRL_SRC_MSB 1
`define BCDO_CTRL_RATE_LSB 2
`define BCDO_CTRL_RATE_MSB 4
`define BCDO_CTRL_TEST_BIT 8

// reset values
`define BCDO_CTRL_RESET 32'h0000_0000
`define BCDO_TEST_RESET 24'h00_0000
`define BCDO_MASK_RESET 4'h0

// interrupt status bits
`define BCDO_IRQ_UPDATE 0
`define BCDO_IRQ_HOLD 1
`define BCDO_IRQ_LOGIC 2
`define BCDO_IRQ_OVER 3
`define BCDO_IRQ_BITS 4

// timing: shortest update period (2000 per second) and the clock period
`define BCDO_BASE_PERIOD_NS 500000
`define BCDO_CLK_PERIOD_NS 20
`define BCDO_BASE_CYCLES (`BCDO_BASE_PERIOD_NS / `BCDO_CLK_PERIOD_NS)

// period multipliers of the base period for rate codes 0..7
// codes: 10, 20, 50, 100, 200, 500, 1000, 2000 updates per second
`define BCDO_RATE_MUL0 200
`define BCDO_RATE_MUL1 100
`define BCDO_RATE_MUL2 40
`define BCDO_RATE_MUL3 20
`define BCDO_RATE_MUL4 10
`define BCDO_RATE_MUL5 4
`define BCDO_RATE_MUL6 2
`define BCDO_RATE_MUL7 1

`endif
